// ===== rtl/fhl_top.sv
// fault history log top: parameter register port and process data flags
// assumes a same-clock parameter channel with one-cycle read/write strobes
`timescale 1ns/1ps
module fhl_top
	import fhl_pkg::*;
(
	input wire logic clk, // system clock, 40 MHz
	input wire logic sys_rst, // sync reset, active high
	input wire logic faultEvt, // fault occurrence pulse
	input wire logic [15:0] faultNum, // fault number
	input wire logic [2:0] faultCls, // fault class code
	input wire logic [15:0] faultQual, // fault qualifier
	input wire logic [31:0] opSeconds, // operating hours counter, seconds
	input wire logic faultResetCmd, // fault reset command pulse
	input wire logic modeReq, // mode request pulse
	input wire logic modeOk, // mode request can be processed
	input wire logic [15:0] modeFaultNum, // cause if it cannot
	input wire logic telegramValid, // valid telegram sent, pulse
	input wire logic regWr, // register write strobe
	input wire logic regRd, // register read strobe
	input wire logic [15:0] regAddr, // register index
	input wire logic [31:0] regWdata, // write data
	output logic [31:0] regRdata, // read data, valid cycle after regRd
	output logic regAck, // read/write done pulse
	output logic [15:0] driveStatusWord, // process_word_one
	output logic [15:0] modeStatusWord, // mode status in reply
	output logic modeAccepted // pulse: mode request taken
);
	fhl_entry_t rdEntry;
	fhl_entry_t snap_q;
	fhl_entry_t newEntry;
	logic [3:0] count;
	logic [3:0] rdPtr_q;
	logic eraseBusy;
	logic eraseReq;
	logic logEn;
	logic faultActive;
	logic [15:0] stopCause;
	logic modeReject_q;
	logic [15:0] modeFault_q;
	logic numRead;

	// time clamped to its documented range
	assign newEntry.num = faultNum;
	assign newEntry.cls = faultCls;
	assign newEntry.tim = (opSeconds > FHL_TIME_MAX) ? FHL_TIME_MAX
		: opSeconds;
	assign newEntry.qual = faultQual;

	fhl_fault_latch uLatch (
		.clk(clk),
		.sys_rst(sys_rst),
		.faultEvt(faultEvt),
		.faultNum(faultNum),
		.faultCls(faultCls),
		.faultResetCmd(faultResetCmd),
		.logEn(logEn),
		.faultActive(faultActive),
		.stopCause(stopCause)
	);

	fhl_store uStore (
		.clk(clk),
		.sys_rst(sys_rst),
		.wrEn(logEn),
		.wrEntry(newEntry),
		.eraseReq(eraseReq),
		.rdPos(rdPtr_q),
		.rdEntry(rdEntry),
		.count(count),
		.eraseBusy(eraseBusy)
	);

	// decoded log clear write command and fault number read
	assign eraseReq = regWr && regAddr == FHL_ADDR_LOG_CLEAR
		&& regWdata[15:0] == 16'h1;
	assign numRead = regRd && regAddr == FHL_ADDR_FAULT_NUM;

	// sequential read pointer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdPtr_q <= 4'(FHL_DEPTH);
		end else if (regWr && regAddr == FHL_ADDR_PTR_REWIND
			&& regWdata[15:0] == 16'h1) begin
			rdPtr_q <= 4'h0;
		end else if (numRead && rdPtr_q < 4'(FHL_DEPTH)) begin
			rdPtr_q <= rdPtr_q + 4'h1;
		end
	end

	// snapshot of the addressed entry, empty when nothing is stored there
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			snap_q <= '0;
		end else if (numRead) begin
			snap_q <= (rdPtr_q < count) ? rdEntry : '0;
		end
	end

	// mode rejection flag; a new rejection wins over the telegram clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			modeReject_q <= 1'b0;
			modeFault_q <= 16'h0;
		end else if (modeReq && !modeOk) begin
			modeReject_q <= 1'b1;
			modeFault_q <= modeFaultNum;
		end else if (telegramValid) begin
			modeReject_q <= 1'b0;
		end
	end
	assign modeAccepted = modeReq && modeOk;

	// process data status words
	always_comb begin
		driveStatusWord = 16'h0;
		driveStatusWord[FHL_BIT_DRIVE_FAULT] = faultActive;
		modeStatusWord = 16'h0;
		modeStatusWord[FHL_BIT_MODE_REJECT] = modeReject_q;
	end

	// register read mux, one cycle latency; unmapped reads give 0
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata <= 32'h0;
			regAck <= 1'b0;
		end else begin
			regAck <= regRd || regWr;
			if (regRd) begin
				unique case (regAddr)
					FHL_ADDR_LOG_CLEAR: regRdata <= {31'h0, eraseBusy};
					FHL_ADDR_PTR_REWIND: regRdata <= 32'h0;
					FHL_ADDR_FAULT_NUM: regRdata <= (rdPtr_q < count)
						? {16'h0, rdEntry.num} : 32'h0;
					FHL_ADDR_FAULT_CLASS: regRdata <= {29'h0, snap_q.cls};
					FHL_ADDR_FAULT_TIME: regRdata <= snap_q.tim;
					FHL_ADDR_QUALIFIER: regRdata <= {16'h0, snap_q.qual};
					FHL_ADDR_LAST_STOP: regRdata <= {16'h0, stopCause};
					FHL_ADDR_MODE_FAULT: regRdata <= {16'h0, modeFault_q};
					default: regRdata <= 32'h0;
				endcase
			end
		end
	end
endmodule

// ===== rtl/fhl_pkg.sv
// constants, types and field layouts of the fault history log
// assumes one system clock and a parameter-channel style register port
// Operation
// - keep the ten most recent faults in storage that survives power loss
// - writing 1 to log_clear erases all entries; reads 1 busy, 0 done
// - writing 1 to pointer_rewind moves read pointer to oldest entry
// - entries read only in sequence; rewind first, each read advances by one
// - pointer past stored entries gives fault number 0
// - position 1 is oldest; when full, position 10 is newest
// - reading fault number snapshots whole entry and advances the pointer
// - class codes 0 warning, 1..3 stops and fatal, 4 unacknowledgeable fatal
// - fault time is 32-bit seconds from hours counter, 0 to 536870911
// - qualifier is a 16-bit value whose meaning depends on fault number
// - bit 15 of drive status word set whenever a fault is present
// - unprocessable mode request rejected, mode status bit 6 set, run goes on
// - fault number of the mode rejection readable at index 6962:00
// - mode rejection flag clears on the next valid data telegram
// - last stop cause holds latest stop fault number, 0 with no fault
// - log only the triggering fault, not faults that follow from it
// - class 4 faults survive reset command; only power cycle clears them
package fhl_pkg;
	localparam int FHL_DEPTH = 10;
	localparam logic [15:0] FHL_ADDR_LOG_CLEAR = 16'h3b08;
	localparam logic [15:0] FHL_ADDR_PTR_REWIND = 16'h3b0a;
	localparam logic [15:0] FHL_ADDR_FAULT_NUM = 16'h3c02;
	localparam logic [15:0] FHL_ADDR_FAULT_CLASS = 16'h3c04;
	localparam logic [15:0] FHL_ADDR_FAULT_TIME = 16'h3c06;
	localparam logic [15:0] FHL_ADDR_QUALIFIER = 16'h3c08;
	localparam logic [15:0] FHL_ADDR_LAST_STOP = 16'h3c10;
	localparam logic [15:0] FHL_ADDR_MODE_FAULT = 16'h6962;
	localparam int FHL_BIT_DRIVE_FAULT = 15;
	localparam int FHL_BIT_MODE_REJECT = 6;
	localparam logic [2:0] FHL_CLASS_WARN = 3'h0;
	localparam logic [2:0] FHL_CLASS_QSTOP7 = 3'h1;
	localparam logic [2:0] FHL_CLASS_QSTOP89 = 3'h2;
	localparam logic [2:0] FHL_CLASS_FATAL_ACK = 3'h3;
	localparam logic [2:0] FHL_CLASS_FATAL_NOACK = 3'h4;
	localparam logic [31:0] FHL_TIME_MAX = 32'h1fffffff;
	localparam logic [3:0] FHL_ERASE_CYCLES = 4'ha;
	// one stored entry: number, class, time, qualifier
	typedef struct packed {
		logic [15:0] num;
		logic [2:0] cls;
		logic [31:0] tim;
		logic [15:0] qual;
	} fhl_entry_t;
	localparam int FHL_ENTRY_W = 67;
	function automatic logic [3:0] fhl_wrap(input logic [3:0] idx);
		fhl_wrap = (idx == 4'(FHL_DEPTH - 1)) ? 4'h0 : idx + 4'h1;
	endfunction
endpackage

// ===== rtl/fhl_store.sv
// ring store of fault entries, written oldest-first, with erase sequencing
// assumes array, head and fill level sit in retained storage
// a fresh part holds unknown contents until its first erase
`timescale 1ns/1ps
module fhl_store
	import fhl_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset, does not wipe contents
	input wire logic wrEn, // append an entry
	input wire fhl_entry_t wrEntry, // entry to append
	input wire logic eraseReq, // start erasing all entries
	input wire logic [3:0] rdPos, // position from oldest, 0 based
	output fhl_entry_t rdEntry, // entry at rdPos
	output logic [3:0] count, // stored entries
	output logic eraseBusy // erase in progress
);
	fhl_entry_t mem [FHL_DEPTH];
	logic [3:0] head_q;
	logic [3:0] count_q;
	logic [3:0] eraseCnt_q;
	logic [4:0] idxSum;

	// memory array; contents are deliberately not reset so they persist
	always_ff @(posedge clk) begin
		if (eraseBusy) begin
			mem[eraseCnt_q] <= '0;
		end else if (wrEn) begin
			mem[head_q] <= wrEntry;
		end
	end

	// head and fill level are retained like the array, so only an erase
	// clears them; a power cycle leaves the history readable
	always_ff @(posedge clk) begin
		if (eraseBusy) begin
			head_q <= 4'h0;
			count_q <= 4'h0;
		end else if (wrEn) begin
			head_q <= fhl_wrap(head_q);
			if (count_q != 4'(FHL_DEPTH)) begin
				count_q <= count_q + 4'h1;
			end
		end
	end

	// erase sequencer walks every slot once
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eraseCnt_q <= 4'h0;
			eraseBusy <= 1'b0;
		end else if (eraseBusy) begin
			eraseCnt_q <= eraseCnt_q + 4'h1;
			if (eraseCnt_q == FHL_ERASE_CYCLES - 4'h1) begin
				eraseBusy <= 1'b0;
			end
		end else if (eraseReq) begin
			eraseCnt_q <= 4'h0;
			eraseBusy <= 1'b1;
		end
	end

	// oldest slot is head when full, else slot 0
	always_comb begin
		idxSum = (count_q == 4'(FHL_DEPTH)) ? {1'b0, head_q} + {1'b0, rdPos}
			: {1'b0, rdPos};
		if (idxSum >= 5'(FHL_DEPTH)) begin
			idxSum = idxSum - 5'(FHL_DEPTH);
		end
		rdEntry = mem[idxSum[3:0]];
	end
	assign count = count_q;
endmodule

// ===== rtl/fhl_fault_latch.sv
// active fault latch: filters consequential faults, keeps class 4 sticky
// assumes faults arrive as single-cycle pulses from same-clock logic
`timescale 1ns/1ps
module fhl_fault_latch
	import fhl_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset (power-on)
	input wire logic faultEvt, // new fault pulse
	input wire logic [15:0] faultNum, // its fault number
	input wire logic [2:0] faultCls, // its class
	input wire logic faultResetCmd, // fault reset command pulse
	output logic logEn, // pulse: record this fault
	output logic faultActive, // a fault is present
	output logic [15:0] stopCause // last stop fault number, 0 if none
);
	logic [15:0] cause_q;
	logic [2:0] cls_q;
	logic active_q;

	// only the first fault while none is active is logged
	assign logEn = faultEvt && !active_q;

	// hold triggering cause; class 4 ignores reset command
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_q <= 1'b0;
			cause_q <= 16'h0;
			cls_q <= FHL_CLASS_WARN;
		end else if (logEn) begin
			active_q <= 1'b1;
			cause_q <= faultNum;
			cls_q <= faultCls;
		end else if (faultResetCmd && cls_q != FHL_CLASS_FATAL_NOACK) begin
			active_q <= 1'b0;
			cause_q <= 16'h0;
		end
	end
	assign faultActive = active_q;
	assign stopCause = cause_q;
endmodule

// ===== test/fhl_monitor.sv
// checker on the fault history log top ports
// assumes bind into every fhl_top, single clock domain
`timescale 1ns/1ps
module fhl_monitor (
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset, active high
	input wire logic faultEvt, // fault pulse
	input wire logic faultResetCmd, // fault reset command
	input wire logic modeReq, // mode request
	input wire logic modeOk, // mode can be processed
	input wire logic telegramValid, // valid telegram
	input wire logic modeAccepted, // mode taken
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	input wire logic regAck, // access done
	input wire logic [31:0] regRdata, // read data
	input wire logic [15:0] driveStatusWord, // fault flag word
	input wire logic [15:0] modeStatusWord // reject flag word
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ack_after_strobe: assert property ((regRd || regWr) |=> regAck)
		else $error("no ack after strobe");
	a_ack_needs_strobe: assert property (regAck |-> $past(regRd || regWr))
		else $error("ack without strobe");
	a_snapshot_holds: assert property
		(!$past(regRd) && !$past(sys_rst) |-> $stable(regRdata))
		else $error("read data moved without read");
	a_fault_sets_flag: assert property (faultEvt |=> driveStatusWord[15])
		else $error("fault flag not set");
	a_fault_flag_holds: assert property
		(driveStatusWord[15] && !faultResetCmd && !sys_rst
			|=> driveStatusWord[15])
		else $error("fault flag dropped");
	a_reject_sets: assert property
		(modeReq && !modeOk |=> modeStatusWord[6])
		else $error("reject flag not set");
	a_reject_clears: assert property
		(telegramValid && !(modeReq && !modeOk) |=> !modeStatusWord[6])
		else $error("reject flag not cleared");
	a_reject_holds: assert property
		(modeStatusWord[6] && !telegramValid && !sys_rst
			|=> modeStatusWord[6])
		else $error("reject flag dropped");
	a_accept_pulse: assert property (modeAccepted == (modeReq && modeOk))
		else $error("accept pulse wrong");
endmodule
bind fhl_top fhl_monitor mon_u (.*);

// ===== test/fhl_host.sv
// host model: parameter channel master with one-cycle strobes
// assumes the bench calls acc and checks tmo afterwards
`timescale 1ns/1ps
module fhl_host (
	input wire logic clk, // system clock
	input wire logic regAck, // access done
	input wire logic [31:0] regRdata, // read data
	output logic regWr = 1'b0, // write strobe
	output logic regRd = 1'b0, // read strobe
	output logic [15:0] regAddr = 16'h0, // register index
	output logic [31:0] regWdata = 32'h0, // write data
	output logic tmo = 1'b0 // access got no ack
);
	// strobe for one cycle, take data at the ack, index scrambled after
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		int i;
		@(posedge clk);
		regWr <= w;
		regRd <= !w;
		regAddr <= a;
		regWdata <= wd;
		@(posedge clk);
		regWr <= 1'b0;
		regRd <= 1'b0;
		regAddr <= ~a;
		#1;
		for (i = 0; i < 8 && regAck !== 1'b1; i++)
			@(posedge clk) #1;
		d = regRdata;
		tmo = (i == 8);
	endtask
endmodule

// ===== test/fault_history_log_tb.sv
// self-checking bench for the fault history log top
// assumes fhl_host as register master and fhl_monitor bound in
`timescale 1ns/1ps
module fault_history_log_tb;
	import fhl_pkg::*;
	logic clk = 0, sys_rst = 1, faultEvt = 0, faultResetCmd = 0;
	logic modeReq = 0, modeOk = 0, telegramValid = 0;
	logic [15:0] faultNum = 0, faultQual = 0, modeFaultNum = 0;
	logic [2:0] faultCls = 0;
	logic [31:0] opSeconds = 0, rdat;
	logic regWr, regRd, regAck, modeAccepted, tmo;
	logic [15:0] regAddr, driveStatusWord, modeStatusWord;
	logic [31:0] regWdata, regRdata;
	int nErrors = 0, cmpCount = 0, seed = 32'h4c55, i;
	fhl_entry_t q[$], e;
	always #12.5 clk = ~clk;
	fhl_top dut_u (.*);
	fhl_host host_u (.*);
	task reportAndStop;
		$display("errors %0d compares %0d", nErrors, cmpCount);
		if (nErrors == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rw(input logic w, input logic [15:0] a, input logic [31:0] d);
		host_u.acc(w, a, d, rdat);
		if (tmo) begin
			nErrors++;
			reportAndStop;
		end
	endtask
	function automatic logic [31:0] clampt(logic [31:0] t);
		return (t > FHL_TIME_MAX) ? FHL_TIME_MAX : t;
	endfunction
	task clear_fault;
		@(posedge clk);
		faultResetCmd <= 1'b1;
		@(posedge clk);
		faultResetCmd <= 1'b0;
	endtask
	// raise one fault, record the expected entry, optionally acknowledge
	task fault(input logic [2:0] c, input logic [31:0] t, input bit clr);
		@(posedge clk);
		faultEvt <= 1'b1;
		faultNum <= 16'($random(seed)) | 16'h1;
		faultCls <= c;
		faultQual <= 16'($random(seed));
		opSeconds <= t;
		@(posedge clk);
		faultEvt <= 1'b0;
		e = '{faultNum, c, clampt(t), faultQual};
		q.push_back(e);
		if (q.size() > FHL_DEPTH)
			void'(q.pop_front());
		#1 chk(driveStatusWord[15], 1);
		rw(0, FHL_ADDR_LAST_STOP, 0);
		chk(rdat, e.num);
		if (clr)
			clear_fault;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		// retained log starts unknown, so bring it to empty first
		rw(1, FHL_ADDR_LOG_CLEAR, 1);
		repeat (12) @(posedge clk);
		rw(0, FHL_ADDR_LOG_CLEAR, 0);
		chk(rdat, 0);
		rw(0, 16'h0000, 0);
		chk(rdat, 0);
		rw(0, FHL_ADDR_FAULT_NUM, 0);
		chk(rdat, 0);
		// twelve faults overflow the ring, random times, the fourth at 32'hffffffff above range
		for (i = 0; i < 12; i++)
			fault(3'(i % 4), (i == 3) ? 32'hffffffff : $random(seed), 1);
		// a consequential fault while active is not logged
		fault(FHL_CLASS_QSTOP89, 32'h5, 0);
		@(posedge clk);
		faultEvt <= 1'b1;
		@(posedge clk);
		faultEvt <= 1'b0;
		clear_fault;
		rw(0, FHL_ADDR_LAST_STOP, 0);
		chk(rdat, 0);
		rw(1, FHL_ADDR_PTR_REWIND, 1);
		for (i = 0; i <= FHL_DEPTH; i++) begin
			e = (i < q.size()) ? q[i] : '0;
			rw(0, FHL_ADDR_FAULT_NUM, 0);
			chk(rdat, e.num);
			rw(0, FHL_ADDR_FAULT_CLASS, 0);
			chk(rdat, 32'(e.cls));
			rw(0, FHL_ADDR_FAULT_TIME, 0);
			chk(rdat, e.tim);
			rw(0, FHL_ADDR_QUALIFIER, 0);
			chk(rdat, 32'(e.qual));
			rw(0, FHL_ADDR_FAULT_CLASS, 0);
			chk(rdat, 32'(e.cls));
		end
		// rejected mode request, accepted one, then a telegram
		@(posedge clk);
		modeReq <= 1'b1;
		modeFaultNum <= 16'($random(seed));
		@(posedge clk);
		modeReq <= 1'b0;
		#1 chk(modeStatusWord[6], 1);
		rw(0, FHL_ADDR_MODE_FAULT, 0);
		chk(rdat, 32'(modeFaultNum));
		@(posedge clk);
		modeReq <= 1'b1;
		modeOk <= 1'b1;
		#1 chk(modeAccepted, 1);
		@(posedge clk);
		modeReq <= 1'b0;
		telegramValid <= 1'b1;
		@(posedge clk);
		telegramValid <= 1'b0;
		#1 chk(modeStatusWord[6], 0);
		fault(FHL_CLASS_FATAL_NOACK, 32'h7, 1);
		#1 chk(driveStatusWord[15], 1);
		// newest entry sits at position ten, class 4 read back
		rw(1, FHL_ADDR_PTR_REWIND, 1);
		for (i = 0; i < FHL_DEPTH; i++)
			rw(0, FHL_ADDR_FAULT_NUM, 0);
		chk(rdat, e.num);
		rw(0, FHL_ADDR_FAULT_CLASS, 0);
		chk(rdat, 32'(FHL_CLASS_FATAL_NOACK));
		// power cycle: the class 4 fault goes, the history stays
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		#1 chk(driveStatusWord[15], 0);
		rw(1, FHL_ADDR_PTR_REWIND, 1);
		rw(0, FHL_ADDR_FAULT_NUM, 0);
		chk(rdat, q[0].num);
		rw(1, FHL_ADDR_LOG_CLEAR, 1);
		rw(0, FHL_ADDR_LOG_CLEAR, 0);
		chk(rdat, 1);
		for (i = 0; i < 20 && rdat !== 32'h0; i++)
			rw(0, FHL_ADDR_LOG_CLEAR, 0);
		chk(rdat, 0);
		rw(1, FHL_ADDR_PTR_REWIND, 1);
		rw(0, FHL_ADDR_FAULT_NUM, 0);
		chk(rdat, 0);
		reportAndStop;
	end
endmodule
